//--- rtl/pcstk_core.sv
// Program counter loading, return stack, context shadows and their register port.
//
// How it works
// [RULE1] Fifteen-bit program counter; low byte is a register, high bits come from the latch.
// [RULE2] Any reset clears the whole program counter.
// [RULE3] Writing the low byte loads bits 14:8 from the latch at the same moment.
// [RULE4] A direct call loads eleven operand bits and latch bits 6:3 on top.
// [RULE5] An indirect call loads the low byte from W and high byte from latch.
// [RULE6] Relative branch by W adds W unsigned to the incremented counter.
// [RULE7] Relative branch by literal adds the signed operand to the incremented counter.
// [RULE8] Sixteen entries of fifteen bits, outside program and data space.
// [RULE9] Calls and interrupt entry push; the three return kinds pop.
// [RULE10] Pushes and pops never alter the high latch; return from interrupt reloads it from its shadow here.
// [RULE11] With the reset option off the stack wraps around circularly.
// [RULE12] Overflow and underflow flags are set whatever the reset option.
// [RULE13] Top-of-stack registers read and write the entry chosen by the pointer.
// [RULE14] Pointer is five bits; empty is 0x1f; first push selects entry zero.
// [RULE15] A push increments then writes; a pop reads then decrements.
// [RULE16] With the reset option on, overflow or underflow resets the device.
// [RULE17] Interrupt entry saves the context into shadows; return from interrupt restores it.
// [RULE18] Shadows keep their contents across reset; undefined after power-up.
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
module pcstk_core #(
  parameter logic [14:0] IRQ_VECTOR = 15'h0004
) (
  input wire logic clk,
  input wire logic nrst,
  input wire pcstk_pkg::pcstk_op_s op_req,
  input wire pcstk_pkg::pcstk_ctx_s ctx_in,
  input wire logic [pcstk_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic [pcstk_pkg::PC_W-1:0] pc_out,
  output logic ctx_restore_valid,
  output pcstk_pkg::pcstk_ctx_s ctx_restore,
  output logic device_reset_req,
  output logic irq
);
  import pcstk_pkg::*;

  // ****************************************
  // State
  // ****************************************
  logic [PC_W-1:0] pc_reg;
  logic [PC_W-1:0] pc_next;
  logic [6:0] pc_high_latch_reg;
  logic [SP_W-1:0] sp_reg;
  logic [SP_W-1:0] sp_next;
  logic [1:0] event_reg;
  logic [1:0] mask_reg;
  logic stack_overflow_reset_enable_reg;
  logic [7:0] rdata_reg;
  logic restore_reg;
  logic reset_req_reg;
  logic irq_reg;
  logic [2:0] status_shadow_reg;
  logic [7:0] w_shadow_reg;
  logic [4:0] bsr_shadow_reg;
  logic [6:0] pc_high_latch_shadow_reg;
  logic [15:0] fsr0_shadow_reg;
  logic [15:0] fsr1_shadow_reg;

  // ****************************************
  // Operation decode
  // ****************************************
  logic is_push;
  logic is_pop;
  logic ovf;
  logic unf;
  logic trap;
  logic [SP_W-1:0] sp_push;
  logic [SP_W-1:0] sp_pop;
  logic [PC_W-1:0] pc_inc;
  logic [PC_W-1:0] tos_data;
  logic mem_wr;
  logic [3:0] mem_idx;
  logic [PC_W-1:0] mem_wdata;
  logic wr_pcl;
  logic wr_pc_high_latch;
  logic wr_sp;
  logic wr_top_of_stack_low;
  logic wr_top_of_stack_high;

  function automatic logic bus_hit(input logic strobe, input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] off);
    bus_hit = strobe && (addr == off);
  endfunction

  assign is_push = (op_req.op == PCSTK_OP_CALL) || (op_req.op == PCSTK_OP_CALL_INDIRECT_W) ||
                   (op_req.op == PCSTK_OP_IRQ); // RULE9
  assign is_pop = (op_req.op == PCSTK_OP_RETURN) || (op_req.op == PCSTK_OP_RETLIT) ||
                  (op_req.op == PCSTK_OP_RETINT); // RULE9
  assign ovf = is_push && (sp_reg == SP_TOP);
  assign unf = is_pop && (sp_reg == SP_EMPTY);
  assign trap = stack_overflow_reset_enable_reg && (ovf || unf); // RULE16
  // Bit 4 is dropped so the seventeenth push lands on entry zero again.
  assign sp_push = {1'b0, sp_reg[3:0] + 4'h1}; // RULE11 RULE14
  assign sp_pop = (sp_reg == SP_BOTTOM) ? SP_EMPTY : {1'b0, sp_reg[3:0] - 4'h1}; // RULE14
  assign pc_inc = pc_reg + 15'h0001;
  assign wr_pcl = bus_hit(reg_wr, reg_addr, OFF_PC_LOW);
  assign wr_pc_high_latch = bus_hit(reg_wr, reg_addr, OFF_PC_HIGH_LATCH);
  assign wr_sp = bus_hit(reg_wr, reg_addr, OFF_RETURN_STACK_POINTER);
  assign wr_top_of_stack_low = bus_hit(reg_wr, reg_addr, OFF_TOP_OF_STACK_LOW);
  assign wr_top_of_stack_high = bus_hit(reg_wr, reg_addr, OFF_TOP_OF_STACK_HIGH);

  // ****************************************
  // Return stack storage
  // ****************************************
  always_comb begin
    mem_wr = 1'b0;
    mem_idx = sp_reg[3:0];
    mem_wdata = tos_data;
    if (is_push && !trap) begin
      mem_wr = 1'b1; // RULE15
      mem_idx = sp_push[3:0];
      mem_wdata = pc_reg;
    end else if (wr_top_of_stack_low) begin
      mem_wr = 1'b1; // RULE13
      mem_wdata = {tos_data[14:8], reg_wdata};
    end else if (wr_top_of_stack_high) begin
      mem_wr = 1'b1; // RULE13
      mem_wdata = {reg_wdata[6:0], tos_data[7:0]};
    end
  end

  pcstk_stack_mem #(
    .DEPTH(STACK_DEPTH),
    .WIDTH(PC_W)
  ) u_stack ( // RULE8
    .clk(clk),
    .wr_en(mem_wr),
    .wr_idx(mem_idx),
    .wr_data(mem_wdata),
    .rd_idx(sp_reg[3:0]),
    .rd_data(tos_data)
  );

  // ****************************************
  // Program counter
  // ****************************************
  always_comb begin
    pc_next = pc_reg;
    unique case (op_req.op)
      PCSTK_OP_NONE: pc_next = pc_reg;
      PCSTK_OP_ADVANCE: pc_next = pc_inc;
      PCSTK_OP_CALL: pc_next = {pc_high_latch_reg[6:3], op_req.operand}; // RULE4
      PCSTK_OP_CALL_INDIRECT_W: pc_next = {pc_high_latch_reg, op_req.w}; // RULE5
      PCSTK_OP_BRW: pc_next = pc_inc + {7'h00, op_req.w}; // RULE6
      PCSTK_OP_BRA: pc_next = pc_inc + {{6{op_req.operand[8]}}, op_req.operand[8:0]}; // RULE7
      PCSTK_OP_RETURN, PCSTK_OP_RETLIT, PCSTK_OP_RETINT: pc_next = tos_data; // RULE15
      PCSTK_OP_IRQ: pc_next = IRQ_VECTOR;
      default: pc_next = pc_reg;
    endcase
    if (wr_pcl) begin
      pc_next = {pc_high_latch_reg, reg_wdata}; // RULE3
    end
    if (trap) begin
      pc_next = PC_RESET; // RULE16
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pc_reg <= PC_RESET; // RULE2
    end else begin
      pc_reg <= pc_next; // RULE1
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pc_high_latch_reg <= PC_HIGH_LATCH_RESET;
    end else if (wr_pc_high_latch) begin
      pc_high_latch_reg <= reg_wdata[6:0]; // RULE1 RULE10
    end else if (op_req.op == PCSTK_OP_RETINT) begin
      pc_high_latch_reg <= pc_high_latch_shadow_reg; // RULE17
    end
  end

  // ****************************************
  // Stack pointer
  // ****************************************
  always_comb begin
    sp_next = sp_reg;
    if (trap) begin
      sp_next = SP_EMPTY; // RULE16
    end else if (is_push) begin
      sp_next = sp_push; // RULE15
    end else if (is_pop) begin
      sp_next = sp_pop; // RULE15
    end else if (wr_sp) begin
      sp_next = reg_wdata[4:0]; // RULE13
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sp_reg <= SP_EMPTY; // RULE14
    end else begin
      sp_reg <= sp_next;
    end
  end

  // ****************************************
  // Stack events, mask and interrupt
  // ****************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      event_reg <= EVENT_RESET;
    end else begin
      // A new event wins over a clear written in the same cycle.
      event_reg[EV_OVF] <= ovf || (event_reg[EV_OVF] &&
                           !(bus_hit(reg_wr, reg_addr, OFF_EVENT_STATUS) && reg_wdata[EV_OVF])); // RULE12
      event_reg[EV_UNF] <= unf || (event_reg[EV_UNF] &&
                           !(bus_hit(reg_wr, reg_addr, OFF_EVENT_STATUS) && reg_wdata[EV_UNF])); // RULE12
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      mask_reg <= EVENT_RESET;
      stack_overflow_reset_enable_reg <= CFG_STACK_OVERFLOW_RESET_ENABLE_RESET;
    end else begin
      if (bus_hit(reg_wr, reg_addr, OFF_EVENT_MASK)) begin
        mask_reg <= reg_wdata[1:0];
      end
      if (bus_hit(reg_wr, reg_addr, OFF_STACK_CFG)) begin
        stack_overflow_reset_enable_reg <= reg_wdata[CFG_STACK_OVERFLOW_RESET_ENABLE];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq_reg <= 1'b0;
      reset_req_reg <= 1'b0;
      restore_reg <= 1'b0;
    end else begin
      irq_reg <= |(event_reg & mask_reg);
      reset_req_reg <= trap; // RULE16
      restore_reg <= (op_req.op == PCSTK_OP_RETINT); // RULE17
    end
  end

  // ****************************************
  // Context shadows
  // ****************************************
  // No reset branch: contents survive every reset and start undefined.
  always_ff @(posedge clk) begin
    if (op_req.op == PCSTK_OP_IRQ) begin
      status_shadow_reg <= ctx_in.status; // RULE17 RULE18
      w_shadow_reg <= ctx_in.w;
      bsr_shadow_reg <= ctx_in.bsr;
      pc_high_latch_shadow_reg <= pc_high_latch_reg;
      fsr0_shadow_reg <= ctx_in.fsr0;
      fsr1_shadow_reg <= ctx_in.fsr1;
    end else if (reg_wr) begin
      unique case (reg_addr)
        OFF_STATUS_FLAGS_SHADOW: status_shadow_reg <= reg_wdata[2:0];
        OFF_WORK_REG_SHADOW: w_shadow_reg <= reg_wdata;
        OFF_BANK_SELECT_SHADOW: bsr_shadow_reg <= reg_wdata[4:0];
        OFF_PC_HIGH_LATCH_SHADOW: pc_high_latch_shadow_reg <= reg_wdata[6:0];
        OFF_INDIRECT0_LOW_SHADOW: fsr0_shadow_reg[7:0] <= reg_wdata;
        OFF_INDIRECT0_HIGH_SHADOW: fsr0_shadow_reg[15:8] <= reg_wdata;
        OFF_INDIRECT1_LOW_SHADOW: fsr1_shadow_reg[7:0] <= reg_wdata;
        OFF_INDIRECT1_HIGH_SHADOW: fsr1_shadow_reg[15:8] <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ****************************************
  // Register read port
  // ****************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        OFF_PC_LOW: rdata_reg <= pc_reg[7:0];
        OFF_PC_HIGH_LATCH: rdata_reg <= {1'b0, pc_high_latch_reg};
        OFF_EVENT_STATUS: rdata_reg <= {6'h00, event_reg};
        OFF_EVENT_MASK: rdata_reg <= {6'h00, mask_reg};
        OFF_STACK_CFG: rdata_reg <= {7'h00, stack_overflow_reset_enable_reg};
        OFF_STATUS_FLAGS_SHADOW: rdata_reg <= {5'h00, status_shadow_reg};
        OFF_WORK_REG_SHADOW: rdata_reg <= w_shadow_reg;
        OFF_BANK_SELECT_SHADOW: rdata_reg <= {3'h0, bsr_shadow_reg};
        OFF_PC_HIGH_LATCH_SHADOW: rdata_reg <= {1'b0, pc_high_latch_shadow_reg};
        OFF_INDIRECT0_LOW_SHADOW: rdata_reg <= fsr0_shadow_reg[7:0];
        OFF_INDIRECT0_HIGH_SHADOW: rdata_reg <= fsr0_shadow_reg[15:8];
        OFF_INDIRECT1_LOW_SHADOW: rdata_reg <= fsr1_shadow_reg[7:0];
        OFF_INDIRECT1_HIGH_SHADOW: rdata_reg <= fsr1_shadow_reg[15:8];
        OFF_RETURN_STACK_POINTER: rdata_reg <= {3'h0, sp_reg};
        OFF_TOP_OF_STACK_LOW: rdata_reg <= tos_data[7:0]; // RULE13
        OFF_TOP_OF_STACK_HIGH: rdata_reg <= {1'b0, tos_data[14:8]}; // RULE13
        default: rdata_reg <= 8'h00;
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata = rdata_reg;
  assign pc_out = pc_reg;
  assign irq = irq_reg;
  assign device_reset_req = reset_req_reg;
  assign ctx_restore_valid = restore_reg;
  assign ctx_restore = '{status: status_shadow_reg, w: w_shadow_reg, bsr: bsr_shadow_reg,
                         fsr0: fsr0_shadow_reg, fsr1: fsr1_shadow_reg};

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_pc_reset_clear: assert property ($rose(nrst) |-> pc_reg == PC_RESET) // RULE2
    else $error("program counter not cleared by reset");
  chk_pcl_write_load: assert property (wr_pcl && !trap |=> // RULE3
      pc_reg == {$past(pc_high_latch_reg), $past(reg_wdata)})
    else $error("low byte write did not load the latch bits");
  chk_call_target: assert property (op_req.op == PCSTK_OP_CALL && !wr_pcl && !trap |=> // RULE4
      pc_reg == {$past(pc_high_latch_reg[6:3]), $past(op_req.operand)})
    else $error("direct call target wrong");
  chk_call_indirect_w_target: assert property (op_req.op == PCSTK_OP_CALL_INDIRECT_W && !wr_pcl && !trap |=> // RULE5
      pc_reg[7:0] == $past(op_req.w) && pc_reg[14:8] == $past(pc_high_latch_reg))
    else $error("indirect call target wrong");
  chk_brw_target: assert property (op_req.op == PCSTK_OP_BRW && !wr_pcl |=> // RULE6
      pc_reg == 15'($past(pc_reg) + 15'h0001 + {7'h00, $past(op_req.w)}))
    else $error("branch by W target wrong");
  // Pointer values 0x10 to 0x1e written by software do not come back after a push and pop.
  chk_push_then_pop: assert property (is_push && !trap && (sp_reg < SP_TOP || sp_reg == SP_EMPTY) ##1 // RULE15
      is_pop && !wr_pcl |=> pc_reg == $past(pc_reg, 2) && sp_reg == $past(sp_reg, 2))
    else $error("pop did not return the pushed address");
  chk_first_push: assert property (is_push && sp_reg == SP_EMPTY |=> sp_reg == SP_BOTTOM) // RULE14
    else $error("first push did not select entry zero");
  chk_latch_kept: assert property ((is_push || op_req.op == PCSTK_OP_RETURN) && !wr_pc_high_latch |=> // RULE10
      $stable(pc_high_latch_reg))
    else $error("stack operation changed the high latch");
  chk_wrap_around: assert property (is_push && sp_reg == SP_TOP && !stack_overflow_reset_enable_reg |=> // RULE11
      sp_reg == SP_BOTTOM && event_reg[EV_OVF])
    else $error("overflow push did not wrap");
  // A clear written right after the event may drop the flag, so the second cycle excludes it.
  chk_underflow_flag: assert property (unf ##1 // RULE12
      !(bus_hit(reg_wr, reg_addr, OFF_EVENT_STATUS) && reg_wdata[EV_UNF]) |->
      event_reg[EV_UNF] ##1 event_reg[EV_UNF])
    else $error("underflow flag not held");
  chk_trap_reset: assert property (trap |=> pc_reg == PC_RESET && sp_reg == SP_EMPTY && // RULE16
      device_reset_req)
    else $error("stack trap did not reset");

endmodule

//--- common/pcstk_pkg.sv
// Shared constants, operation codes and carriers for the program counter and return stack.
package pcstk_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int PC_W = 15;
  localparam int ADDR_W = 12;
  localparam int OPND_W = 11;
  localparam int BRA_W = 9;
  localparam int STACK_DEPTH = 16;
  localparam int SP_W = 5;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [ADDR_W-1:0] OFF_PC_LOW = 12'hfd0;
  localparam logic [ADDR_W-1:0] OFF_PC_HIGH_LATCH = 12'hfd1;
  localparam logic [ADDR_W-1:0] OFF_EVENT_STATUS = 12'hfd2;
  localparam logic [ADDR_W-1:0] OFF_EVENT_MASK = 12'hfd3;
  localparam logic [ADDR_W-1:0] OFF_STACK_CFG = 12'hfd4;
  localparam logic [ADDR_W-1:0] OFF_STATUS_FLAGS_SHADOW = 12'hfe4;
  localparam logic [ADDR_W-1:0] OFF_WORK_REG_SHADOW = 12'hfe5;
  localparam logic [ADDR_W-1:0] OFF_BANK_SELECT_SHADOW = 12'hfe6;
  localparam logic [ADDR_W-1:0] OFF_PC_HIGH_LATCH_SHADOW = 12'hfe7;
  localparam logic [ADDR_W-1:0] OFF_INDIRECT0_LOW_SHADOW = 12'hfe8;
  localparam logic [ADDR_W-1:0] OFF_INDIRECT0_HIGH_SHADOW = 12'hfe9;
  localparam logic [ADDR_W-1:0] OFF_INDIRECT1_LOW_SHADOW = 12'hfea;
  localparam logic [ADDR_W-1:0] OFF_INDIRECT1_HIGH_SHADOW = 12'hfeb;
  localparam logic [ADDR_W-1:0] OFF_RETURN_STACK_POINTER = 12'hfed;
  localparam logic [ADDR_W-1:0] OFF_TOP_OF_STACK_LOW = 12'hfee;
  localparam logic [ADDR_W-1:0] OFF_TOP_OF_STACK_HIGH = 12'hfef;

  // ****************************************
  // Reset values and field positions
  // ****************************************
  localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
  localparam logic [6:0] PC_HIGH_LATCH_RESET = 7'h00;
  localparam logic [SP_W-1:0] SP_EMPTY = 5'h1f;
  localparam logic [SP_W-1:0] SP_TOP = 5'h0f;
  localparam logic [SP_W-1:0] SP_BOTTOM = 5'h00;
  localparam int EV_OVF = 0;
  localparam int EV_UNF = 1;
  localparam int CFG_STACK_OVERFLOW_RESET_ENABLE = 0;
  localparam logic [1:0] EVENT_RESET = 2'h0;
  localparam logic CFG_STACK_OVERFLOW_RESET_ENABLE_RESET = 1'b1;

  // ****************************************
  // Operations and carriers
  // ****************************************
  typedef enum logic [3:0] {
    PCSTK_OP_NONE = 4'h0,
    PCSTK_OP_ADVANCE = 4'h1,
    PCSTK_OP_CALL = 4'h2,
    PCSTK_OP_CALL_INDIRECT_W = 4'h3,
    PCSTK_OP_BRW = 4'h4,
    PCSTK_OP_BRA = 4'h5,
    PCSTK_OP_RETURN = 4'h6,
    PCSTK_OP_RETLIT = 4'h7,
    PCSTK_OP_RETINT = 4'h8,
    PCSTK_OP_IRQ = 4'h9
  } pcstk_op_e;

  typedef struct packed {
    pcstk_op_e op;
    logic [OPND_W-1:0] operand;
    logic [7:0] w;
  } pcstk_op_s;

  typedef struct packed {
    logic [2:0] status;
    logic [7:0] w;
    logic [4:0] bsr;
    logic [15:0] fsr0;
    logic [15:0] fsr1;
  } pcstk_ctx_s;

endpackage

//--- rtl/pcstk_stack_mem.sv
// Return stack storage: one write port and one asynchronous read port.
`timescale 1ns/1ps
module pcstk_stack_mem #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 15
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_idx,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_idx,
  output logic [WIDTH-1:0] rd_data
);

  // The entries hold no reset value; they are undefined until written.
  logic [WIDTH-1:0] entry_mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      entry_mem[wr_idx] <= wr_data;
    end
  end

  assign rd_data = entry_mem[rd_idx];

endmodule

//--- tb/pcstk_core_model.sv
// Behavioural model of the instruction execution and interrupt logic that drives the core.
`timescale 1ns/1ps
module pcstk_core_model (
  input wire logic clk,
  output pcstk_pkg::pcstk_op_s op_req,
  output pcstk_pkg::pcstk_ctx_s ctx_in
);
  import pcstk_pkg::*;

  initial begin
    op_req = '0;
    ctx_in = '0;
  end

  // Holds one operation for exactly one cycle, then scrambles the fields so a late sample shows.
  task automatic issue(input pcstk_op_e o, input logic [10:0] opnd, input logic [7:0] w, input pcstk_ctx_s c);
    @(posedge clk);
    op_req <= '{op: o, operand: opnd, w: w};
    ctx_in <= c;
    @(posedge clk);
    op_req <= '{op: PCSTK_OP_NONE, operand: ~opnd, w: ~w};
    ctx_in <= ~c;
  endtask
endmodule

//--- tb/testbench.sv
// Self-checking testbench for the program counter and return stack.
`timescale 1ns/1ps
module testbench;
  import pcstk_pkg::*;
  localparam logic [14:0] VEC = 15'h0004;
  localparam logic [ADDR_W-1:0] PTR = OFF_RETURN_STACK_POINTER;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [PC_W-1:0] pc_out;
  logic ctx_restore_valid;
  logic device_reset_req;
  logic irq;
  pcstk_op_s op_req;
  pcstk_ctx_s ctx_in;
  pcstk_ctx_s ctx_restore;
  pcstk_ctx_s ctx_a = '{status: 3'h5, w: 8'ha6, bsr: 5'h13, fsr0: 16'h1234, fsr1: 16'hbeef};
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;

  always #5 clk = ~clk;

  pcstk_core_model core (.clk(clk), .op_req(op_req), .ctx_in(ctx_in));

  pcstk_core #(.IRQ_VECTOR(VEC)) dut (.clk(clk), .nrst(nrst), .op_req(op_req), .ctx_in(ctx_in),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pc_out(pc_out), .ctx_restore_valid(ctx_restore_valid), .ctx_restore(ctx_restore),
    .device_reset_req(device_reset_req), .irq(irq));

  // ****************************************
  // Checks, bus cycles and closing
  // ****************************************
  task automatic report_and_stop();
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      $display("ERROR %0t: run did not finish in time", $time);
      report_and_stop();
    end
  end

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: register read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_pc(input logic [PC_W-1:0] got, input logic [PC_W-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: program counter %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic check_ctx(input pcstk_ctx_s got, input pcstk_ctx_s exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: restored context %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_check(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check_byte(reg_rdata, exp);
  endtask

  task automatic do_op(input pcstk_op_e o, input logic [10:0] opnd, input logic [7:0] w);
    core.issue(o, opnd, w, ctx_a);
    #1;
  endtask

  task automatic do_reset();
    nrst <= 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_pc_and_stack();
    check_pc(pc_out, 15'h0000);
    rd_check(PTR, 8'h1f);
    rd_check(12'hfec, 8'h00);
    rd_check(OFF_STACK_CFG, 8'h01);
    wr(OFF_PC_HIGH_LATCH, 8'h35);
    wr(OFF_PC_LOW, 8'h7a);
    #1;
    check_pc(pc_out, 15'h357a);
    do_op(PCSTK_OP_CALL, 11'h123, 8'h00);
    check_pc(pc_out, 15'h3123);
    rd_check(PTR, 8'h00);
    rd_check(OFF_TOP_OF_STACK_LOW, 8'h7a);
    rd_check(OFF_TOP_OF_STACK_HIGH, 8'h35);
    rd_check(OFF_PC_HIGH_LATCH, 8'h35);
    do_op(PCSTK_OP_CALL_INDIRECT_W, 11'h000, 8'h9c);
    check_pc(pc_out, 15'h359c);
    do_op(PCSTK_OP_BRW, 11'h000, 8'hff);
    check_pc(pc_out, 15'h369c);
    do_op(PCSTK_OP_BRA, 11'h1f0, 8'h00);
    check_pc(pc_out, 15'h368d);
    do_op(PCSTK_OP_ADVANCE, 11'h000, 8'h00);
    check_pc(pc_out, 15'h368e);
    do_op(PCSTK_OP_RETURN, 11'h000, 8'h00);
    check_pc(pc_out, 15'h3123);
    do_op(PCSTK_OP_RETLIT, 11'h000, 8'h00);
    check_pc(pc_out, 15'h357a);
    rd_check(PTR, 8'h1f);
  endtask

  task automatic t_irq_context();
    do_op(PCSTK_OP_IRQ, 11'h000, 8'h00);
    check_pc(pc_out, VEC);
    rd_check(OFF_WORK_REG_SHADOW, 8'ha6);
    rd_check(OFF_STATUS_FLAGS_SHADOW, 8'h05);
    rd_check(OFF_INDIRECT1_HIGH_SHADOW, 8'hbe);
    rd_check(OFF_PC_HIGH_LATCH_SHADOW, 8'h35);
    wr(OFF_PC_HIGH_LATCH, 8'h11);
    do_op(PCSTK_OP_RETINT, 11'h000, 8'h00);
    check_bit(ctx_restore_valid, 1'b1);
    check_ctx(ctx_restore, ctx_a);
    check_pc(pc_out, 15'h357a);
    rd_check(OFF_PC_HIGH_LATCH, 8'h35);
    check_bit(ctx_restore_valid, 1'b0);
    @(posedge clk);
    do_reset();
    check_pc(pc_out, 15'h0000);
    rd_check(OFF_WORK_REG_SHADOW, 8'ha6);
    rd_check(OFF_BANK_SELECT_SHADOW, 8'h13);
    wr(OFF_INDIRECT0_LOW_SHADOW, 8'h3c);
    rd_check(OFF_INDIRECT0_LOW_SHADOW, 8'h3c);
    rd_check(OFF_INDIRECT0_HIGH_SHADOW, 8'h12);
  endtask

  task automatic t_overflow_trap();
    wr(OFF_EVENT_MASK, 8'h01);
    for (int i = 0; i < 16; i++) begin
      do_op(PCSTK_OP_CALL, 11'(i), 8'h00);
    end
    rd_check(PTR, 8'h0f);
    do_op(PCSTK_OP_CALL, 11'h7ff, 8'h00);
    check_bit(device_reset_req, 1'b1);
    check_pc(pc_out, 15'h0000);
    rd_check(PTR, 8'h1f);
    rd_check(OFF_EVENT_STATUS, 8'h01);
    check_bit(irq, 1'b1);
    wr(OFF_EVENT_STATUS, 8'h01);
    repeat (2) @(posedge clk);
    #1;
    check_bit(irq, 1'b0);
    do_op(PCSTK_OP_RETURN, 11'h000, 8'h00);
    check_bit(device_reset_req, 1'b1);
    rd_check(OFF_EVENT_STATUS, 8'h02);
    check_bit(irq, 1'b0);
    check_bit(device_reset_req, 1'b0);
    wr(OFF_EVENT_MASK, 8'h02);
    repeat (2) @(posedge clk);
    #1;
    check_bit(irq, 1'b1);
    wr(OFF_EVENT_STATUS, 8'h02);
  endtask

  task automatic t_wrap_and_tos();
    wr(OFF_STACK_CFG, 8'h00);
    wr(OFF_PC_HIGH_LATCH, 8'h35);
    for (int i = 0; i < 17; i++) begin
      do_op(PCSTK_OP_CALL, 11'(i), 8'h00);
    end
    check_bit(device_reset_req, 1'b0);
    rd_check(PTR, 8'h00);
    rd_check(OFF_TOP_OF_STACK_LOW, 8'h0f);
    rd_check(OFF_TOP_OF_STACK_HIGH, 8'h30);
    rd_check(OFF_EVENT_STATUS, 8'h01);
    do_op(PCSTK_OP_RETURN, 11'h000, 8'h00);
    check_pc(pc_out, 15'h300f);
    do_op(PCSTK_OP_RETURN, 11'h000, 8'h00);
    check_pc(pc_out, 15'h300e);
    check_bit(device_reset_req, 1'b0);
    rd_check(PTR, 8'h0e);
    rd_check(OFF_EVENT_STATUS, 8'h03);
    wr(PTR, 8'h03);
    wr(OFF_TOP_OF_STACK_LOW, 8'h5a);
    wr(OFF_TOP_OF_STACK_HIGH, 8'h2b);
    rd_check(OFF_TOP_OF_STACK_LOW, 8'h5a);
    rd_check(OFF_TOP_OF_STACK_HIGH, 8'h2b);
    do_op(PCSTK_OP_RETURN, 11'h000, 8'h00);
    check_pc(pc_out, 15'h2b5a);
    rd_check(PTR, 8'h02);
  endtask

  initial begin
    do_reset();
    t_pc_and_stack();
    t_irq_context();
    t_overflow_trap();
    t_wrap_and_tos();
    report_and_stop();
  end
endmodule
